/* File: include/debug_bp_pkg.sv */
// Constants and types shared by the breakpoint and watchpoint unit
`default_nettype none
package debug_bp_pkg;

    // ****************************************
    // Register offsets (word index)
    // ****************************************
    localparam logic [7:0] OFF_CAUSE      = 8'h15;
    localparam logic [7:0] OFF_CAUSE_DATA = 8'h16;
    localparam logic [7:0] OFF_STOP_MASK  = 8'h18;
    localparam logic [7:0] OFF_SCRATCH    = 8'h20;
    localparam logic [7:0] OFF_IB_ADDR    = 8'h30;
    localparam logic [7:0] OFF_IB_CTRL    = 8'h40;
    localparam logic [7:0] OFF_DW_ADDR1   = 8'h50;
    localparam logic [7:0] OFF_DW_ADDR2   = 8'h60;
    localparam logic [7:0] OFF_DW_CTRL    = 8'h70;
    localparam logic [7:0] OFF_RW_MASK    = 8'h80;
    localparam logic [7:0] OFF_RW_VALUE   = 8'h90;
    localparam logic [7:0] OFF_RW_CTRL    = 8'h9C;

    // ****************************************
    // Field positions and write masks
    // ****************************************
    localparam int CAUSE_CODE_LSB   = 0;
    localparam int CAUSE_THREAD_LSB = 8;
    localparam int CAUSE_INDEX_LSB  = 16;
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_COND_BIT    = 1;
    localparam int CTRL_LOAD_BIT    = 2;
    localparam int CTRL_THREAD_LSB  = 16;
    localparam logic [31:0] IB_CTRL_WMASK = 32'h00FF0003;
    localparam logic [31:0] DW_CTRL_WMASK = 32'h00FF0007;
    localparam logic [31:0] RW_CTRL_WMASK = 32'h00FF0003;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] CTRL_RESET      = 32'h00000000;
    localparam logic [31:0] WORD_RESET      = 32'h00000000;
    localparam logic [7:0]  STOP_MASK_RESET = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        CAUSE_NONE   = 3'h0,
        CAUSE_HOST   = 3'h1,
        CAUSE_CALL   = 3'h2,
        CAUSE_IBREAK = 3'h3,
        CAUSE_DWATCH = 3'h4,
        CAUSE_RWATCH = 3'h5
    } cause_t;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b01,
        ST_HALTED = 2'b10
    } dbg_state_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  thread;
        logic [31:0] pc;
    } pc_event_t;

    typedef struct packed {
        logic        valid;
        logic        isLoad;
        logic [2:0]  thread;
        logic [31:0] addr;
    } mem_event_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  thread;
        logic [31:0] resId;
    } res_event_t;

endpackage
`default_nettype wire

/* File: logic/debug_breakpoint_watchpoint_unit.sv */
// Breakpoint, watchpoint, cause capture and thread stop logic
//
// Behaviour
// - Cause code 1..5 recorded, reset zero
// - Unit index recorded, zero for host/call
// - Lowest-numbered simultaneous unit within a kind wins
// - Thread number recorded, zero for host
// - Data hit loads access address
// - Resource hit loads resource identifier
// - Stop mask holds threads outside debug
// - Eight scratch words shared with config
// - Four instruction breakpoints on PC condition
// - Per-thread enable field, reset zero
// - Condition bit selects PC equal/unequal
// - Bit 0 enables unit, reset off
// - Four data watchpoints, two address banks
// - Condition bit selects AND or OR
// - Load bit makes loads trigger
// - Four resource mask and value pairs
// - Condition bit selects A or B
// - Four resource control registers
`default_nettype none
module debug_breakpoint_watchpoint_unit
    import debug_bp_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output var  logic [31:0] regRdata,
    // Tile configuration scratch port
    input  wire logic [2:0]  cfgAddr,
    input  wire logic [31:0] cfgWdata,
    input  wire logic        cfgWr,
    input  wire logic        cfgRd,
    output var  logic [31:0] cfgRdata,
    // Pipeline events
    input  wire pc_event_t   pcEvent,
    input  wire mem_event_t  memEvent,
    input  wire res_event_t  resEvent,
    input  wire logic        dcallValid,
    input  wire logic [2:0]  dcallThread,
    input  wire logic        hostReq,
    input  wire logic        debugReturn,
    // Debug status out
    output var  logic        debugIrq,
    output var  logic        inDebug,
    output var  logic [7:0]  threadHold
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic inBank4(input logic [7:0] a,
                                     input logic [7:0] base);
        inBank4 = (a[7:2] == base[7:2]);
    endfunction

    function automatic logic [1:0] lowestHit(input logic [3:0] h);
        lowestHit = h[0] ? 2'h0 : h[1] ? 2'h1 : h[2] ? 2'h2 : 2'h3;
    endfunction

    function automatic logic threadOk(input logic [31:0] ctrl,
                                      input logic [2:0]  thr);
        threadOk = ctrl[CTRL_EN_BIT] &&
                   ctrl[CTRL_THREAD_LSB + int'(thr)];
    endfunction

    // ****************************************
    // Storage
    // ****************************************
    logic [31:0] ibAddrReg  [4];
    logic [31:0] ibCtrlReg  [4];
    logic [31:0] dwAddr1Reg [4];
    logic [31:0] dwAddr2Reg [4];
    logic [31:0] dwCtrlReg  [4];
    logic [31:0] rwMaskReg  [4];
    logic [31:0] rwValueReg [4];
    logic [31:0] rwCtrlReg  [4];
    logic [31:0] scratchReg [8];
    cause_t      causeCodeReg;
    logic [7:0]  causeThreadReg;
    logic [1:0]  causeIdxReg;
    logic [31:0] causeDataReg;
    logic [7:0]  stopMaskReg;
    dbg_state_t  stateReg;
    dbg_state_t  stateNext;

    // ****************************************
    // Register decode
    // ****************************************
    wire logic       hitIbAddr  = inBank4(regAddr, OFF_IB_ADDR);
    wire logic       hitIbCtrl  = inBank4(regAddr, OFF_IB_CTRL);
    wire logic       hitDwAddr1 = inBank4(regAddr, OFF_DW_ADDR1);
    wire logic       hitDwAddr2 = inBank4(regAddr, OFF_DW_ADDR2);
    wire logic       hitDwCtrl  = inBank4(regAddr, OFF_DW_CTRL);
    wire logic       hitRwMask  = inBank4(regAddr, OFF_RW_MASK);
    wire logic       hitRwValue = inBank4(regAddr, OFF_RW_VALUE);
    wire logic       hitRwCtrl  = inBank4(regAddr, OFF_RW_CTRL);
    wire logic       hitScratch = (regAddr[7:3] == OFF_SCRATCH[7:3]);
    wire logic       hitCause   = (regAddr == OFF_CAUSE);
    wire logic       hitData    = (regAddr == OFF_CAUSE_DATA);
    wire logic       hitStop    = (regAddr == OFF_STOP_MASK);
    wire logic [1:0] bankIdx    = regAddr[1:0];
    wire logic [2:0] scrIdx     = regAddr[2:0];

    // ****************************************
    // Hit detection
    // ****************************************
    logic [3:0] ibHit;
    logic [3:0] dwHit;
    logic [3:0] rwHit;

    generate
        for (genvar i = 0; i < 4; i++) begin : g_unit
            wire logic pcEq  = (pcEvent.pc == ibAddrReg[i]);
            wire logic dwA   = (memEvent.addr == dwAddr1Reg[i]);
            wire logic dwB   = (memEvent.addr == dwAddr2Reg[i]);
            wire logic dwCnd = dwCtrlReg[i][CTRL_COND_BIT] ?
                               (dwA | dwB) : (dwA & dwB);
            wire logic dwDir = (memEvent.isLoad ==
                                dwCtrlReg[i][CTRL_LOAD_BIT]);
            wire logic rwA   = ((resEvent.resId & rwMaskReg[i]) ==
                                rwValueReg[i]);
            wire logic rwB   = (resEvent.resId == rwValueReg[i]);
            wire logic rwCnd = rwCtrlReg[i][CTRL_COND_BIT] ? rwB : rwA;
            assign ibHit[i] = pcEvent.valid &&
                              threadOk(ibCtrlReg[i], pcEvent.thread) &&
                              (pcEq ^ ibCtrlReg[i][CTRL_COND_BIT]);
            assign dwHit[i] = memEvent.valid && dwCnd && dwDir &&
                              threadOk(dwCtrlReg[i], memEvent.thread);
            assign rwHit[i] = resEvent.valid &&
                              threadOk(rwCtrlReg[i], resEvent.thread) &&
                              rwCnd;
        end
    endgenerate

    // ****************************************
    // Cause selection
    // ****************************************
    // Kinds are ranked by cause code; within a kind the lowest unit wins
    wire logic   anyIb   = |ibHit;
    wire logic   anyDw   = |dwHit;
    wire logic   anyRw   = |rwHit;
    wire logic   evAny   = hostReq | dcallValid | anyIb | anyDw | anyRw;
    wire logic   evTake  = evAny && (stateReg == ST_RUN);
    wire cause_t newCode = hostReq    ? CAUSE_HOST   :
                           dcallValid ? CAUSE_CALL   :
                           anyIb      ? CAUSE_IBREAK :
                           anyDw      ? CAUSE_DWATCH : CAUSE_RWATCH;
    wire logic [2:0] newThr = hostReq    ? 3'h0 :
                              dcallValid ? dcallThread :
                              anyIb      ? pcEvent.thread :
                              anyDw      ? memEvent.thread :
                                           resEvent.thread;
    wire logic [1:0] newIdx = (hostReq | dcallValid) ? 2'h0 :
                              anyIb ? lowestHit(ibHit) :
                              anyDw ? lowestHit(dwHit) :
                                      lowestHit(rwHit);
    wire logic [31:0] newData =
        (newCode == CAUSE_DWATCH) ? memEvent.addr  :
        (newCode == CAUSE_RWATCH) ? resEvent.resId : causeDataReg;

    // ****************************************
    // Debug state
    // ****************************************
    // Events while halted are dropped so the captured cause stays intact
    always_comb begin
        case (stateReg)
            ST_RUN:    stateNext = evAny ? ST_HALTED : ST_RUN;
            ST_HALTED: stateNext = debugReturn ? ST_RUN : ST_HALTED;
            default:   stateNext = ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg   <= ST_RUN;
            debugIrq   <= 1'b0;
            inDebug    <= 1'b0;
            threadHold <= 8'h00;
        end else begin
            stateReg   <= stateNext;
            debugIrq   <= evTake;
            inDebug    <= (stateNext == ST_HALTED);
            threadHold <= (stateNext == ST_RUN) ? stopMaskReg : 8'h00;
        end
    end

    // ****************************************
    // Cause registers
    // ****************************************
    // A captured event wins over a software write in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            causeCodeReg   <= CAUSE_NONE;
            causeThreadReg <= 8'h00;
            causeIdxReg    <= 2'h0;
            causeDataReg   <= WORD_RESET;
            stopMaskReg    <= STOP_MASK_RESET;
        end else begin
            if (evTake) begin
                causeCodeReg   <= newCode;
                causeThreadReg <= {5'h00, newThr};
                causeIdxReg    <= newIdx;
            end else if (regWr && hitCause) begin
                causeCodeReg   <= cause_t'(regWdata[CAUSE_CODE_LSB +: 3]);
                causeThreadReg <= regWdata[CAUSE_THREAD_LSB +: 8];
                causeIdxReg    <= regWdata[CAUSE_INDEX_LSB +: 2];
            end
            if (evTake)
                causeDataReg <= newData;
            else if (regWr && hitData)
                causeDataReg <= regWdata;
            if (regWr && hitStop)
                stopMaskReg <= regWdata[7:0];
        end
    end

    // ****************************************
    // Banks and scratch
    // ****************************************
    generate
        for (genvar i = 0; i < 4; i++) begin : g_bank
            wire logic wrSel = regWr && (bankIdx == 2'(i));
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ibAddrReg[i]  <= WORD_RESET;
                    ibCtrlReg[i]  <= CTRL_RESET;
                    dwAddr1Reg[i] <= WORD_RESET;
                    dwAddr2Reg[i] <= WORD_RESET;
                    dwCtrlReg[i]  <= CTRL_RESET;
                    rwMaskReg[i]  <= WORD_RESET;
                    rwValueReg[i] <= WORD_RESET;
                    rwCtrlReg[i]  <= CTRL_RESET;
                end else if (wrSel) begin
                    if (hitIbAddr)  ibAddrReg[i]  <= regWdata;
                    if (hitIbCtrl)  ibCtrlReg[i]  <= regWdata & IB_CTRL_WMASK;
                    if (hitDwAddr1) dwAddr1Reg[i] <= regWdata;
                    if (hitDwAddr2) dwAddr2Reg[i] <= regWdata;
                    if (hitDwCtrl)  dwCtrlReg[i]  <= regWdata & DW_CTRL_WMASK;
                    if (hitRwMask)  rwMaskReg[i]  <= regWdata;
                    if (hitRwValue) rwValueReg[i] <= regWdata;
                    if (hitRwCtrl)  rwCtrlReg[i]  <= regWdata & RW_CTRL_WMASK;
                end
            end
        end
        // One storage, two ports; the register port wins a same-word clash
        for (genvar s = 0; s < 8; s++) begin : g_scratch
            wire logic regSel = regWr && hitScratch && (scrIdx == 3'(s));
            wire logic cfgSel = cfgWr && (cfgAddr == 3'(s));
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n)
                    scratchReg[s] <= WORD_RESET;
                else if (regSel)
                    scratchReg[s] <= regWdata;
                else if (cfgSel)
                    scratchReg[s] <= cfgWdata;
            end
        end
    endgenerate

    // ****************************************
    // Read path
    // ****************************************
    wire logic [31:0] causeWord = {14'h0000, causeIdxReg, causeThreadReg,
                                   5'h00, causeCodeReg};
    wire logic [31:0] readMux =
        hitCause   ? causeWord :
        hitData    ? causeDataReg :
        hitStop    ? {24'h000000, stopMaskReg} :
        hitScratch ? scratchReg[scrIdx] :
        hitIbAddr  ? ibAddrReg[bankIdx] :
        hitIbCtrl  ? ibCtrlReg[bankIdx] :
        hitDwAddr1 ? dwAddr1Reg[bankIdx] :
        hitDwAddr2 ? dwAddr2Reg[bankIdx] :
        hitDwCtrl  ? dwCtrlReg[bankIdx] :
        hitRwMask  ? rwMaskReg[bankIdx] :
        hitRwValue ? rwValueReg[bankIdx] :
        hitRwCtrl  ? rwCtrlReg[bankIdx] : 32'h00000000;

    // Read data stand for the one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h00000000;
            cfgRdata <= 32'h00000000;
        end else begin
            regRdata <= regRd ? readMux : 32'h00000000;
            cfgRdata <= cfgRd ? scratchReg[cfgAddr] : 32'h00000000;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_dw_only;
        stateReg == ST_RUN && !hostReq && !dcallValid && !anyIb && anyDw;
    endsequence
    sequence s_rw_only;
        stateReg == ST_RUN && !hostReq && !dcallValid && !anyIb &&
            !anyDw && anyRw;
    endsequence
    sequence s_cfg_write;
        cfgWr && !regWr;
    endsequence

    a_irq_cause_valid: assert property (
        debugIrq |-> causeCodeReg inside {[CAUSE_HOST:CAUSE_RWATCH]})
        else $error("debug irq with invalid cause");
    a_host_zero_fields: assert property (
        debugIrq && causeCodeReg == CAUSE_HOST |->
            causeIdxReg == 2'h0 && causeThreadReg == 8'h00)
        else $error("host cause with nonzero index or thread");
    a_lowest_unit: assert property (
        s_dw_only |=> debugIrq && causeIdxReg == lowestHit($past(dwHit)))
        else $error("watchpoint index not lowest");
    a_data_addr_load: assert property (
        s_dw_only |=> causeCodeReg == CAUSE_DWATCH &&
            causeDataReg == $past(memEvent.addr))
        else $error("data watch address not captured");
    a_res_id_load: assert property (
        s_rw_only |=> causeCodeReg == CAUSE_RWATCH &&
            causeDataReg == $past(resEvent.resId))
        else $error("resource id not captured");
    a_stop_hold: assert property (
        stateReg == ST_RUN && !evAny |=> threadHold == $past(stopMaskReg))
        else $error("stop mask not applied outside debug");
    a_halt_release: assert property (
        debugIrq |-> threadHold == 8'h00 && inDebug)
        else $error("threads held during debug entry");
    a_scratch_shared: assert property (
        s_cfg_write ##1 (regRd && hitScratch && scrIdx == $past(cfgAddr))
            |=> regRdata == $past(cfgWdata, 2))
        else $error("scratch word not shared");
    a_disabled_silent: assert property (
        !ibCtrlReg[0][CTRL_EN_BIT] |-> !ibHit[0])
        else $error("disabled breakpoint fired");
    a_thread_gate: assert property (
        pcEvent.valid && !ibCtrlReg[1][CTRL_THREAD_LSB + int'(pcEvent.thread)]
            |-> !ibHit[1])
        else $error("breakpoint fired for masked thread");

endmodule
`default_nettype wire

/* File: verif/pipe_model.sv */
// Behavioural pipeline and debugger model that raises events on request
`default_nettype none
module pipe_model
    import debug_bp_pkg::*;
(
    // Clock
    input  wire logic        core_clk,
    // Request from the bench
    input  wire logic        req,
    input  wire logic [2:0]  kind,
    input  wire logic [2:0]  thr,
    input  wire logic [31:0] val,
    input  wire logic        isLoad,
    // Events towards the unit
    output var  pc_event_t   pcEvent,
    output var  mem_event_t  memEvent,
    output var  res_event_t  resEvent,
    output var  logic        dcallValid,
    output var  logic [2:0]  dcallThread,
    output var  logic        hostReq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] lastVal = 32'h0;
    logic [2:0]  lastThr = 3'h0;

    // Idle fields show the inverse of the last value, never stale data
    wire logic [31:0] fVal = req ? val : ~lastVal;
    wire logic [2:0]  fThr = req ? thr : ~lastThr;

    always @(posedge core_clk) begin
        if (req) begin
            lastVal <= val;
            lastThr <= thr;
        end
    end

    assign pcEvent     = {req && kind == 3'h0, fThr, fVal};
    assign memEvent    = {req && kind == 3'h1, isLoad, fThr, fVal};
    assign resEvent    = {req && kind == 3'h2, fThr, fVal};
    assign dcallValid  = req && kind == 3'h3;
    assign dcallThread = fThr;
    assign hostReq     = req && kind == 3'h4;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the breakpoint and watchpoint unit
`default_nettype none
module tb
    import debug_bp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk, rst_n, regWr, regRd, cfgWr, cfgRd;
    logic [7:0]  regAddr, threadHold, stopMask;
    logic [31:0] regWdata, regRdata, cfgWdata, cfgRdata, val;
    logic [2:0]  cfgAddr, kind, thr, dcallThread;
    logic        dcallValid, hostReq, debugReturn, req, isLoad;
    logic        debugIrq, inDebug;
    pc_event_t   pcEvent;
    mem_event_t  memEvent;
    res_event_t  resEvent;
    int          badCount = 0;
    int          checksDone = 0;

    debug_breakpoint_watchpoint_unit u_dut (.core_clk, .rst_n, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .cfgAddr, .cfgWdata, .cfgWr,
        .cfgRd, .cfgRdata, .pcEvent, .memEvent, .resEvent, .dcallValid,
        .dcallThread, .hostReq, .debugReturn, .debugIrq, .inDebug,
        .threadHold);

    pipe_model u_pipe (.core_clk, .req, .kind, .thr, .val, .isLoad,
        .pcEvent, .memEvent, .resEvent, .dcallValid, .dcallThread,
        .hostReq);

    task automatic check_word(input logic [31:0] got, exp, input string s);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, exp, input string s);
        check_word({31'h0, got}, {31'h0, exp}, s);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 check_word(regRdata, exp, "reg read");
    endtask

    task automatic cfg(input logic w, input logic [2:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        cfgWr    <= w;
        cfgRd    <= !w;
        cfgAddr  <= a;
        cfgWdata <= d;
        @(posedge core_clk);
        cfgWr <= 1'b0;
        cfgRd <= 1'b0;
        #1 if (!w) check_word(cfgRdata, d, "cfg read");
    endtask

    // One event, then the whole halt and resume round when it must hit
    task automatic fire(input logic [2:0] k, t, input logic [31:0] v,
                        input logic ld, hit, input logic [31:0] c, d);
        @(posedge core_clk);
        req    <= 1'b1;
        kind   <= k;
        thr    <= t;
        val    <= v;
        isLoad <= ld;
        @(posedge core_clk);
        req <= 1'b0;
        #1 check_flag(debugIrq, hit, "irq");
        if (hit) begin
            check_flag(inDebug, 1'b1, "halted");
            check_word({24'h0, threadHold}, 32'h0, "hold in debug");
            // A request while halted must be dropped and keep the cause
            @(posedge core_clk);
            req  <= 1'b1;
            kind <= 3'h4;
            @(posedge core_clk);
            req <= 1'b0;
            #1 check_flag(debugIrq, 1'b0, "event while halted");
            @(posedge core_clk);
            debugReturn <= 1'b1;
            @(posedge core_clk);
            debugReturn <= 1'b0;
            #1 check_flag(inDebug, 1'b0, "resumed");
            check_word({24'h0, threadHold}, {24'h0, stopMask}, "hold");
            rd(OFF_CAUSE, c);
            if (k == 3'h1 || k == 3'h2) rd(OFF_CAUSE_DATA, d);
        end
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #100us;
        badCount++;
        endOfTest();
    end

    initial begin
        {rst_n, regWr, regRd, cfgWr, cfgRd, debugReturn, req, isLoad} = '0;
        {regAddr, regWdata, cfgAddr, cfgWdata, kind, thr, val} = '0;
        stopMask = 8'h00;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(OFF_CAUSE, 32'h0);
        rd(OFF_STOP_MASK, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(OFF_IB_CTRL + 8'(i), 32'h0);
            rd(OFF_DW_CTRL + 8'(i), 32'h0);
            rd(OFF_RW_CTRL + 8'(i), 32'h0);
        end
        wr(8'h43, 32'hFFFFFFFF);
        rd(8'h43, 32'h00FF0003);
        wr(8'h72, 32'hFFFFFFFF);
        rd(8'h72, 32'h00FF0007);
        wr(8'h9F, 32'hFFFFFFFF);
        rd(8'h9F, 32'h00FF0003);
        wr(8'h43, 32'h0);
        wr(8'h72, 32'h0);
        wr(8'h9F, 32'h0);
        wr(8'h01, 32'h12345678);
        rd(8'h01, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(OFF_SCRATCH + 8'(i), {24'hC0DE00, 8'(i)});
        end
        for (int i = 0; i < 8; i++) begin
            cfg(1'b0, 3'(i), {24'hC0DE00, 8'(i)});
        end
        // Config write then register read back to back, no gap
        @(posedge core_clk);
        cfgWr    <= 1'b1;
        cfgAddr  <= 3'h5;
        cfgWdata <= 32'h5A5A0005;
        @(posedge core_clk);
        cfgWr   <= 1'b0;
        regRd   <= 1'b1;
        regAddr <= 8'h25;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 check_word(regRdata, 32'h5A5A0005, "shared word");
        wr(OFF_STOP_MASK, 32'h000000A5);
        stopMask = 8'hA5;
        rd(OFF_STOP_MASK, 32'h000000A5);
        check_word({24'h0, threadHold}, 32'hA5, "hold running");
        $display("test scratch done");
        wr(8'h31, 32'h1000);
        wr(8'h32, 32'h1000);
        wr(8'h41, 32'h00080001);
        wr(8'h42, 32'h00080001);
        rd(8'h31, 32'h1000);
        fire(0, 3, 32'h1000, 0, 1, 32'h00010303, 0);
        fire(0, 2, 32'h1000, 0, 0, 0, 0);
        wr(8'h41, 32'h00080000);
        fire(0, 3, 32'h1000, 0, 1, 32'h00020303, 0);
        wr(8'h42, 32'h00080003);
        fire(0, 3, 32'h1000, 0, 0, 0, 0);
        fire(0, 3, 32'h1004, 0, 1, 32'h00020303, 0);
        wr(8'h42, 32'h0);
        $display("test instruction break done");
        wr(8'h53, 32'h200);
        wr(8'h63, 32'h300);
        rd(8'h63, 32'h300);
        wr(8'h73, 32'h00200005);
        fire(1, 5, 32'h200, 1, 0, 0, 0);
        wr(8'h73, 32'h00200007);
        fire(1, 5, 32'h300, 1, 1, 32'h00030504, 32'h300);
        fire(1, 5, 32'h300, 0, 0, 0, 0);
        wr(8'h73, 32'h00200003);
        fire(1, 5, 32'h200, 0, 1, 32'h00030504, 32'h200);
        wr(8'h73, 32'h0);
        $display("test data watch done");
        wr(8'h80, 32'hFF);
        wr(8'h90, 32'h12);
        rd(8'h80, 32'hFF);
        wr(8'h9C, 32'h00010001);
        fire(2, 0, 32'hAB12, 0, 1, 32'h5, 32'hAB12);
        wr(8'h9C, 32'h00010003);
        fire(2, 0, 32'hAB12, 0, 0, 0, 0);
        fire(2, 0, 32'h12, 0, 1, 32'h5, 32'h12);
        $display("test resource watch done");
        fire(4, 7, 0, 0, 1, 32'h1, 0);
        fire(3, 6, 0, 0, 1, 32'h00000602, 0);
        $display("test host and call done");
        endOfTest();
    end
endmodule
`default_nettype wire
